// [logic/dcs_pkg.sv]
`default_nettype none

package dcs_pkg;

  // Channel count and field widths.
  localparam int          DCS_CHANS      = 16;
  localparam int          DCS_CW         = 4;
  localparam int          DCS_DW         = 32;

  // Register word indices; the byte address is four times the index.
  localparam logic [31:0] DCS_IDX_REQ_FULL   = 32'hfc044026;
  localparam logic [31:0] DCS_IDX_FAULT_FULL = 32'hfc04402e;
  localparam logic [7:0]  DCS_IDX_REQ    = DCS_IDX_REQ_FULL[7:0];
  localparam logic [7:0]  DCS_IDX_FAULT  = DCS_IDX_FAULT_FULL[7:0];
  localparam logic [7:0]  DCS_IDX_RCLR   = 8'h1c;
  localparam logic [7:0]  DCS_IDX_FCLR   = 8'h1d;
  localparam logic [7:0]  DCS_IDX_FEN    = 8'h20;
  localparam logic [7:0]  DCS_IDX_CTRL   = 8'h21;
  localparam logic [7:0]  DCS_IDX_STAT   = 8'h22;
  localparam logic [3:0]  DCS_IDX_PRIO_HI = 4'h4;

  // Address bits that carry the word index.
  localparam int          DCS_IDX_LSB    = 2;
  localparam int          DCS_IDX_MSB    = 9;

  // Field positions of the clear ports, priority registers and control register.
  localparam int          DCS_CLR_ALL_BIT = 6;
  localparam int          DCS_PRI_LVL_MSB = 3;
  localparam int          DCS_PRI_PEN_BIT = 7;
  localparam int          DCS_CTRL_RR_BIT = 0;

  // Status register field positions.
  localparam int          DCS_ST_CFG_BIT  = 0;
  localparam int          DCS_ST_GNT_BIT  = 1;
  localparam int          DCS_ST_PRE_BIT  = 2;
  localparam int          DCS_ST_CH_LSB   = 4;

  // Reset values.
  localparam logic [15:0] DCS_BITS_RST   = 16'h0000;
  localparam logic [15:0] DCS_FEN_RST    = 16'h0000;

  // AHB encodings.
  localparam logic [1:0]  DCS_HTRANS_NSEQ = 2'h2;
  localparam logic        DCS_HRESP_OKAY  = 1'h0;

  // Arbiter states.
  typedef enum logic [3:0] {
    DCS_IDLE    = 4'b0001,
    DCS_RUN     = 4'b0010,
    DCS_PREEMPT = 4'b0100,
    DCS_RESTORE = 4'b1000
  } dcs_arb_t;

endpackage : dcs_pkg

`default_nettype wire

// [logic/dcs_status_priority.sv]
// Functional notes
// - Completion with request enabled sets channel request.
// - Request bits drive interrupt outputs directly.
// - Request register write clears bits written one.
// - Request clear port clears request bits.
// - Channel error sets its fault bit.
// - Fault interrupt is fault AND enable.
// - Errors never alter completion request behaviour.
// - Fault register reads raw bits, ignoring enables.
// - Fault register write clears bits written one.
// - Fault clear port clears fault bits.
// - Fixed priority: larger level wins, zero lowest.
// - Duplicate priority levels raise configuration error.
// - Level in bits 3..0; 6..4 reserved.
// - Bit 7 lets higher request suspend channel.
// - Preempted channel resumes after preemptor's minor loop.
// - Restored channel finishes one sequence, then preemptible.
// - A preempting channel cannot itself be preempted.
// - Preemption only under fixed-priority arbitration.
// - Priority level resets to its channel number.
// - Request and fault bitmaps reset to zero.
// - Request clear: bit 6 all, else index 3..0.
// - Fault clear: bit 6 all, else index 3..0.
//
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module dcs_status_priority (
  // Clock and reset.
  input  wire logic                          clk,
  input  wire logic                          rst,
  // AHB-Lite slave.
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [dcs_pkg::DCS_DW-1:0]    hwdata,
  input  wire logic                          hready,
  output logic      [dcs_pkg::DCS_DW-1:0]    hrdata,
  output logic                               hreadyout,
  output logic                               hresp,
  // Engine events, one-cycle pulses per channel.
  input  wire logic [dcs_pkg::DCS_CHANS-1:0] chanDone,
  input  wire logic [dcs_pkg::DCS_CHANS-1:0] doneReqEn,
  input  wire logic [dcs_pkg::DCS_CHANS-1:0] chanErr,
  // Engine arbitration handshake.
  input  wire logic [dcs_pkg::DCS_CHANS-1:0] chanReq,
  input  wire logic                          minorDone,
  input  wire logic                          rwDone,
  // Interrupt controller requests.
  output logic      [dcs_pkg::DCS_CHANS-1:0] reqIrq,
  output logic      [dcs_pkg::DCS_CHANS-1:0] faultIrq,
  // Arbitration result and configuration status.
  output logic                               grantValid,
  output logic      [dcs_pkg::DCS_CW-1:0]    grantChan,
  output logic                               preemptOn,
  output logic                               cfgErr
);
  import dcs_pkg::*;

  // Builds the clear mask of a clear-port write.
  function automatic logic [DCS_CHANS-1:0] clrMask(input logic [DCS_DW-1:0] d);
    logic [DCS_CHANS-1:0] m;
    m = '0;
    if (d[DCS_CLR_ALL_BIT]) begin
      m = '1;
    end else begin
      m[d[DCS_CW-1:0]] = 1'b1;
    end
    return m;
  endfunction : clrMask

  // Returns the requesting channel with the largest priority level.
  function automatic logic [DCS_CW-1:0] pickHigh(input logic [DCS_CHANS-1:0] req,
                                                 input logic [DCS_CHANS*DCS_CW-1:0] lv);
    logic [DCS_CW-1:0] best;
    logic              found;
    best  = '0;
    found = 1'b0;
    for (int i = 0; i < DCS_CHANS; i++) begin
      if (req[i] && (!found || lv[i*DCS_CW +: DCS_CW] > lv[best*DCS_CW +: DCS_CW])) begin
        best  = DCS_CW'(i);
        found = 1'b1;
      end
    end
    return best;
  endfunction : pickHigh

  // Returns the next requesting channel after the last one served.
  function automatic logic [DCS_CW-1:0] pickNext(input logic [DCS_CHANS-1:0] req,
                                                 input logic [DCS_CW-1:0] last);
    logic [DCS_CW-1:0] k;
    logic [DCS_CW-1:0] sel;
    logic              found;
    sel   = last;
    found = 1'b0;
    for (int i = 1; i <= DCS_CHANS; i++) begin
      k = DCS_CW'(last + DCS_CW'(i));
      if (req[k] && !found) begin
        sel   = k;
        found = 1'b1;
      end
    end
    return sel;
  endfunction : pickNext

  // Register state.
  logic [DCS_CHANS-1:0]        reqBitsReg;
  logic [DCS_CHANS-1:0]        faultBitsReg;
  logic [DCS_CHANS-1:0]        faultEnReg;
  logic                        rrSelReg;
  logic [DCS_CW-1:0]           prioLvlReg [DCS_CHANS];
  logic [DCS_CHANS-1:0]        preEnReg;
  logic                        dWrReg;
  logic [7:0]                  dIdxReg;
  dcs_arb_t                    stReg;
  logic [DCS_CW-1:0]           savedReg;

  // Next values.
  logic [DCS_CHANS-1:0]        reqBitsNext;
  logic [DCS_CHANS-1:0]        faultBitsNext;
  logic [DCS_CHANS-1:0]        faultEnNext;

  // Address phase decode.
  wire                         addrPhase = hsel && htrans[1] && hready;
  wire  [7:0]                  aIdx      = haddr[DCS_IDX_MSB:DCS_IDX_LSB];
  wire                         aPrioHit  = (aIdx[7:4] == DCS_IDX_PRIO_HI);

  // Data phase write strobes.
  wire                         wrReq     = dWrReg && (dIdxReg == DCS_IDX_REQ);
  wire                         wrFault   = dWrReg && (dIdxReg == DCS_IDX_FAULT);
  wire                         wrRclr    = dWrReg && (dIdxReg == DCS_IDX_RCLR);
  wire                         wrFclr    = dWrReg && (dIdxReg == DCS_IDX_FCLR);
  wire                         wrFen     = dWrReg && (dIdxReg == DCS_IDX_FEN);
  wire                         wrCtrl    = dWrReg && (dIdxReg == DCS_IDX_CTRL);
  wire                         wrPrio    = dWrReg && (dIdxReg[7:4] == DCS_IDX_PRIO_HI);

  // Hardware set and software clear masks.
  wire  [DCS_CHANS-1:0]        reqSet    = chanDone & doneReqEn;
  wire  [DCS_CHANS-1:0]        reqClr    = (wrReq ? hwdata[DCS_CHANS-1:0] : '0)
                                         | (wrRclr ? clrMask(hwdata) : '0);
  wire  [DCS_CHANS-1:0]        faultClr  = (wrFault ? hwdata[DCS_CHANS-1:0] : '0)
                                         | (wrFclr ? clrMask(hwdata) : '0);

  // Flattened levels and duplicate check.
  logic [DCS_CHANS*DCS_CW-1:0] lvlFlat;
  logic                        dupLvl;
  always_comb begin
    lvlFlat = '0;
    dupLvl  = 1'b0;
    for (int i = 0; i < DCS_CHANS; i++) begin
      lvlFlat[i*DCS_CW +: DCS_CW] = prioLvlReg[i];
      for (int j = i + 1; j < DCS_CHANS; j++) begin
        if (prioLvlReg[i] == prioLvlReg[j]) begin
          dupLvl = 1'b1;
        end
      end
    end
  end

  // Set wins over clear for both bitmaps.
  always_comb begin
    reqBitsNext   = (reqBitsReg & ~reqClr) | reqSet;
    faultBitsNext = (faultBitsReg & ~faultClr) | chanErr;
    faultEnNext   = wrFen ? hwdata[DCS_CHANS-1:0] : faultEnReg;
  end

  // Read data selection; fault bits are raw, reserved bits read zero.
  wire  [DCS_CW-1:0]           aCh       = aIdx[DCS_CW-1:0];
  wire  [DCS_DW-1:0]           prioWord  = {24'h000000, preEnReg[aCh], 3'h0, prioLvlReg[aCh]};
  wire  [DCS_DW-1:0]           statWord  = {24'h000000, grantChan, 1'b0, preemptOn,
                                            grantValid, cfgErr};
  wire  [DCS_DW-1:0]           readMux   =
      (aIdx == DCS_IDX_REQ)   ? {16'h0000, reqBitsReg}   :
      (aIdx == DCS_IDX_FAULT) ? {16'h0000, faultBitsReg} :
      (aIdx == DCS_IDX_FEN)   ? {16'h0000, faultEnReg}   :
      (aIdx == DCS_IDX_CTRL)  ? {31'h00000000, rrSelReg} :
      (aIdx == DCS_IDX_STAT)  ? statWord                 :
      aPrioHit                ? prioWord                 : 32'h00000000;

  // Bus slave: zero wait states, read data captured in the address phase.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dWrReg    <= 1'b0;
      dIdxReg   <= 8'h00;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= DCS_HRESP_OKAY;
    end else begin
      dWrReg    <= addrPhase && hwrite;
      dIdxReg   <= aIdx;
      hreadyout <= 1'b1;
      hresp     <= DCS_HRESP_OKAY;
      if (addrPhase && !hwrite) begin
        hrdata <= readMux;
      end
    end
  end

  // Bitmaps, enables and interrupt outputs.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reqBitsReg   <= DCS_BITS_RST;
      faultBitsReg <= DCS_BITS_RST;
      faultEnReg   <= DCS_FEN_RST;
      reqIrq       <= DCS_BITS_RST;
      faultIrq     <= DCS_BITS_RST;
      rrSelReg     <= 1'b0;
      cfgErr       <= 1'b0;
    end else begin
      reqBitsReg   <= reqBitsNext;
      faultBitsReg <= faultBitsNext;
      faultEnReg   <= faultEnNext;
      reqIrq       <= reqBitsNext;
      faultIrq     <= faultBitsNext & faultEnNext;
      cfgErr       <= dupLvl;
      if (wrCtrl) begin
        rrSelReg <= hwdata[DCS_CTRL_RR_BIT];
      end
    end
  end

  // Priority registers; reserved bits are not stored.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DCS_CHANS; i++) begin
        prioLvlReg[i] <= DCS_CW'(i);
      end
      preEnReg <= '0;
    end else if (wrPrio) begin
      prioLvlReg[dIdxReg[DCS_CW-1:0]] <= hwdata[DCS_PRI_LVL_MSB:0];
      preEnReg[dIdxReg[DCS_CW-1:0]]   <= hwdata[DCS_PRI_PEN_BIT];
    end
  end

  // Arbitration candidates.
  wire  [DCS_CW-1:0]           hiChan    = pickHigh(chanReq, lvlFlat);
  wire  [DCS_CW-1:0]           rrChan    = pickNext(chanReq, grantChan);
  wire                         anyReq    = |chanReq;
  wire                         hiBeats   = chanReq[hiChan] && (hiChan != grantChan)
                                         && (prioLvlReg[hiChan] > prioLvlReg[grantChan]);
  wire                         doPreempt = !rrSelReg && preEnReg[grantChan]
                                         && hiBeats;

  // Arbiter: preempt, restore after the minor loop, no nesting.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stReg      <= DCS_IDLE;
      savedReg   <= '0;
      grantChan  <= '0;
      grantValid <= 1'b0;
      preemptOn  <= 1'b0;
    end else begin
      case (stReg)
        DCS_IDLE: begin
          if (anyReq) begin
            grantChan  <= rrSelReg ? rrChan : hiChan;
            grantValid <= 1'b1;
            stReg      <= DCS_RUN;
          end
        end
        DCS_RUN: begin
          if (minorDone) begin
            grantValid <= 1'b0;
            stReg      <= DCS_IDLE;
          end else if (doPreempt) begin
            savedReg   <= grantChan;
            grantChan  <= hiChan;
            preemptOn  <= 1'b1;
            stReg      <= DCS_PREEMPT;
          end
        end
        DCS_PREEMPT: begin
          if (minorDone) begin
            grantChan  <= savedReg;
            preemptOn  <= 1'b0;
            stReg      <= DCS_RESTORE;
          end
        end
        DCS_RESTORE: begin
          if (minorDone) begin
            grantValid <= 1'b0;
            stReg      <= DCS_IDLE;
          end else if (rwDone) begin
            stReg      <= DCS_RUN;
          end
        end
        default: begin
          stReg      <= DCS_IDLE;
          grantValid <= 1'b0;
          preemptOn  <= 1'b0;
        end
      endcase
    end
  end

  // Checks.
  chk_req_set_wins: assert property (@(posedge clk) disable iff (rst)
    (reqSet != 16'h0000) |=> ((reqBitsReg & $past(reqSet)) == $past(reqSet)))
    else $error("Completion request was lost.");

  chk_req_irq_direct: assert property (@(posedge clk) disable iff (rst)
    reqIrq == reqBitsReg)
    else $error("Request output differs from request bitmap.");

  chk_req_w1c_keep: assert property (@(posedge clk) disable iff (rst)
    (wrReq && !wrRclr && reqSet == 16'h0000)
      |=> reqBitsReg == ($past(reqBitsReg) & ~$past(hwdata[15:0])))
    else $error("Request write-one-to-clear misbehaved.");

  chk_clr_all_req: assert property (@(posedge clk) disable iff (rst)
    (wrRclr && hwdata[DCS_CLR_ALL_BIT] && reqSet == 16'h0000) |=> reqBitsReg == 16'h0000)
    else $error("Clear-all did not empty the request bitmap.");

  chk_fault_set: assert property (@(posedge clk) disable iff (rst)
    (chanErr != 16'h0000) |=> ((faultBitsReg & $past(chanErr)) == $past(chanErr)))
    else $error("Channel error did not set its fault bit.");

  chk_fault_irq_and: assert property (@(posedge clk) disable iff (rst)
    faultIrq == (faultBitsReg & faultEnReg))
    else $error("Fault interrupt is not gated by its enable.");

  chk_fault_clr_one: assert property (@(posedge clk) disable iff (rst)
    (wrFclr && !hwdata[DCS_CLR_ALL_BIT] && chanErr == 16'h0000 && !wrFault)
      |=> faultBitsReg == ($past(faultBitsReg) & ~(16'h0001 << $past(hwdata[3:0]))))
    else $error("Single fault clear misbehaved.");

  chk_cfg_dup: assert property (@(posedge clk) disable iff (rst)
    (prioLvlReg[0] == prioLvlReg[1]) |=> cfgErr)
    else $error("Duplicate priority not reported.");

  chk_no_nesting: assert property (@(posedge clk) disable iff (rst)
    (stReg == DCS_PREEMPT && !minorDone) |=> (grantChan == $past(grantChan) && preemptOn))
    else $error("Preempting channel was preempted.");

  chk_rr_no_preempt: assert property (@(posedge clk) disable iff (rst)
    (stReg == DCS_RUN && rrSelReg) |=> stReg != DCS_PREEMPT)
    else $error("Preemption under round-robin arbitration.");

  chk_restore_hold: assert property (@(posedge clk) disable iff (rst)
    (stReg == DCS_RESTORE && !rwDone && !minorDone) |=> stReg == DCS_RESTORE)
    else $error("Restored channel preempted before one sequence.");

  chk_fault_w1c_keep: assert property (@(posedge clk) disable iff (rst)
    (wrFault && !wrFclr && chanErr == 16'h0000)
      |=> faultBitsReg == ($past(faultBitsReg) & ~$past(hwdata[15:0])))
    else $error("Fault write-one-to-clear misbehaved.");

  chk_req_clr_one: assert property (@(posedge clk) disable iff (rst)
    (wrRclr && !hwdata[DCS_CLR_ALL_BIT] && reqSet == 16'h0000 && !wrReq)
      |=> reqBitsReg == ($past(reqBitsReg) & ~(16'h0001 << $past(hwdata[3:0]))))
    else $error("Single request clear misbehaved.");

  chk_clr_all_fault: assert property (@(posedge clk) disable iff (rst)
    (wrFclr && hwdata[DCS_CLR_ALL_BIT] && chanErr == 16'h0000) |=> faultBitsReg == 16'h0000)
    else $error("Clear-all did not empty the fault bitmap.");

  chk_raw_fault_read: assert property (@(posedge clk) disable iff (rst)
    (addrPhase && !hwrite && aIdx == DCS_IDX_FAULT)
      |=> hrdata == {16'h0000, $past(faultBitsReg)})
    else $error("Fault bitmap read is not the raw bitmap.");

  chk_locked_no_preempt: assert property (@(posedge clk) disable iff (rst)
    (stReg == DCS_RUN && !preEnReg[grantChan]) |=> stReg != DCS_PREEMPT)
    else $error("Channel without preempt enable was suspended.");

  chk_restore_saved: assert property (@(posedge clk) disable iff (rst)
    (stReg == DCS_PREEMPT && minorDone) |=> (grantChan == $past(savedReg) && !preemptOn))
    else $error("Preempted channel not restored after the minor loop.");

  chk_cfg_unique: assert property (@(posedge clk) disable iff (rst)
    !dupLvl |=> !cfgErr)
    else $error("Configuration error reported with unique priorities.");

endmodule : dcs_status_priority

`default_nettype wire

// [tb/dcs_irq_ctrl_model.sv]
`timescale 1ns/1ps
`default_nettype none

module dcs_irq_ctrl_model (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst,
  // Request lines from the block.
  input  wire logic [15:0] reqIrq,
  input  wire logic [15:0] faultIrq,
  // Pending state as the controller sees it.
  output logic      [15:0] pendReq,
  output logic      [15:0] pendFault
);
  // The controller is level sensitive, so it samples the lines every cycle.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pendReq   <= 16'h0000;
      pendFault <= 16'h0000;
    end else begin
      pendReq   <= reqIrq;
      pendFault <= faultIrq;
    end
  end
endmodule : dcs_irq_ctrl_model

`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import dcs_pkg::*;

  // Bench-driven inputs and bookkeeping.
  logic              clk, rst, hsel, hwrite, minorDone, rwDone;
  logic [31:0]       haddr, hwdata, lfsrState, expQ[$];
  logic [1:0]        htrans;
  logic [15:0]       chanDone, doneReqEn, chanErr, chanReq, evMask, expReq, expErr, e, f;
  wire  logic [31:0] hrdata;
  wire  logic [15:0] reqIrq, faultIrq, pendReq, pendFault;
  wire  logic [3:0]  grantChan;
  wire  logic        hreadyout, hresp, grantValid, preemptOn, cfgErr;
  int                bad_count, comparisons;
  event              rdEv;

  dcs_status_priority dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .chanDone(chanDone),
    .doneReqEn(doneReqEn), .chanErr(chanErr), .chanReq(chanReq), .minorDone(minorDone),
    .rwDone(rwDone), .reqIrq(reqIrq), .faultIrq(faultIrq), .grantValid(grantValid),
    .grantChan(grantChan), .preemptOn(preemptOn), .cfgErr(cfgErr));

  dcs_irq_ctrl_model irqCtl (.clk(clk), .rst(rst), .reqIrq(reqIrq), .faultIrq(faultIrq),
    .pendReq(pendReq), .pendFault(pendFault));

  // Free-running 40 MHz clock.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Compares one value and counts the result.
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Prints the counts and the verdict, then stops.
  task automatic test_done();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done

  // Pseudo-random source with a fixed start.
  function automatic logic [31:0] lfsr();
    lfsrState = {lfsrState[30:0], lfsrState[31] ^ lfsrState[21] ^ lfsrState[1] ^ lfsrState[0]};
    return lfsrState;
  endfunction : lfsr

  function automatic logic [31:0] adr(input logic [7:0] idx);
    return {22'h0, idx, 2'h0};
  endfunction : adr

  function automatic logic [31:0] pri(input int n);
    return {22'h0, DCS_IDX_PRIO_HI, n[3:0], 2'h0};
  endfunction : pri

  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask : step

  // Waits for hready at a rising edge; a slave that never answers is left to the watchdog.
  task automatic waitReady();
    do begin
      @(posedge clk);
    end while (hreadyout !== 1'b1);
  endtask : waitReady

  // One single AHB-Lite transfer; engine events in evMask land in the data phase.
  task automatic busXfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= DCS_HTRANS_NSEQ;
    hwrite <= wr;
    waitReady();
    htrans    <= 2'h0;
    hwdata    <= d;
    chanDone  <= evMask;
    doneReqEn <= evMask;
    chanErr   <= evMask;
    waitReady();
    if (!wr) begin
      ->rdEv;
    end
    chanDone  <= 16'h0;
    chanErr   <= 16'h0;
    hsel      <= 1'b0;
    evMask    = 16'h0;
    step(1);
  endtask : busXfer

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    busXfer(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    expQ.push_back(exp);
    busXfer(1'b0, a, 32'h0);
  endtask : rd

  // Read data is matched against the oldest expectation.
  always @(rdEv) begin
    check("hrdata", hrdata, expQ.pop_front());
  end

  // Checks the arbiter outputs a few cycles after a stimulus.
  task automatic arb(input logic [3:0] ch, input logic pre);
    step(3);
    check("grantValid", {31'h0, grantValid}, 32'h1);
    check("grantChan", {28'h0, grantChan}, {28'h0, ch});
    check("preemptOn", {31'h0, preemptOn}, {31'h0, pre});
  endtask : arb

  task automatic pulse(input logic rw);
    if (rw) rwDone <= 1'b1;
    else minorDone <= 1'b1;
    @(posedge clk);
    rwDone    <= 1'b0;
    minorDone <= 1'b0;
  endtask : pulse

  // Main sequence.
  initial begin
    {rst, hsel, hwrite, minorDone, rwDone} = 5'b10000;
    {haddr, hwdata, htrans} = '0;
    {chanDone, doneReqEn, chanErr, chanReq, evMask} = '0;
    lfsrState = 32'h00013c2f;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int n = 0; n < 16; n++) rd(pri(n), n);
    rd(adr(DCS_IDX_REQ), 32'h0);
    rd(adr(DCS_IDX_FAULT), 32'h0);
    rd(adr(8'h30), 32'h0);
    // Random completions and errors.
    expReq = 16'(lfsr());
    e = 16'(lfsr());
    expErr = 16'(lfsr());
    chanDone <= expReq;
    doneReqEn <= e;
    chanErr <= expErr;
    @(posedge clk);
    chanDone <= 16'h0;
    chanErr <= 16'h0;
    expReq = expReq & e;
    step(2);
    check("reqIrq", {16'h0, reqIrq}, {16'h0, expReq});
    check("pendReq", {16'h0, pendReq}, {16'h0, expReq});
    check("faultIrq", {16'h0, faultIrq}, 32'h0);
    rd(adr(DCS_IDX_FAULT), {16'h0, expErr});
    f = 16'(lfsr());
    wr(adr(DCS_IDX_FEN), {16'h0, f});
    step(1);
    check("pendFault", {16'h0, pendFault}, {16'h0, expErr & f});
    // Write-one-to-clear on both bitmaps.
    e = 16'(lfsr());
    wr(adr(DCS_IDX_REQ), {16'h0, e});
    rd(adr(DCS_IDX_REQ), {16'h0, expReq & ~e});
    wr(adr(DCS_IDX_FAULT), {16'h0, e});
    rd(adr(DCS_IDX_FAULT), {16'h0, expErr & ~e});
    // Clear ports, single index and clear-all.
    evMask = 16'hffff;
    wr(adr(8'h30), 32'h0);
    wr(adr(DCS_IDX_RCLR), 32'h5);
    rd(adr(DCS_IDX_REQ), 32'hffdf);
    wr(adr(DCS_IDX_FCLR), 32'hf);
    rd(adr(DCS_IDX_FAULT), 32'h7fff);
    wr(adr(DCS_IDX_FCLR), 32'h40);
    rd(adr(DCS_IDX_FAULT), 32'h0);
    evMask = 16'h0100;
    wr(adr(DCS_IDX_RCLR), 32'h40);
    rd(adr(DCS_IDX_REQ), 32'h0100);
    evMask = 16'h0008;
    wr(adr(DCS_IDX_FAULT), 32'hffff);
    rd(adr(DCS_IDX_FAULT), 32'h0008);
    // Priority fields and duplicate detection.
    wr(pri(0), 32'h71);
    step(1);
    check("cfgErr", {31'h0, cfgErr}, 32'h1);
    rd(pri(0), 32'h01);
    wr(pri(0), 32'h0);
    step(1);
    check("cfgErr", {31'h0, cfgErr}, 32'h0);
    wr(pri(2), 32'h82);
    rd(pri(2), 32'h82);
    // Fixed priority and preemption.
    chanReq <= 16'h0088;
    arb(4'h7, 1'b0);
    chanReq <= 16'h0004;
    pulse(1'b0);
    arb(4'h2, 1'b0);
    chanReq <= 16'h0024;
    arb(4'h5, 1'b1);
    chanReq <= 16'h0224;
    arb(4'h5, 1'b1);
    chanReq <= 16'h0204;
    pulse(1'b0);
    arb(4'h2, 1'b0);
    pulse(1'b1);
    arb(4'h9, 1'b1);
    chanReq <= 16'h0004;
    pulse(1'b0);
    arb(4'h2, 1'b0);
    // Round robin: the restored channel runs again and a higher level must not suspend it.
    wr(adr(DCS_IDX_CTRL), 32'h1);
    chanReq <= 16'h0024;
    pulse(1'b1);
    arb(4'h2, 1'b0);
    chanReq <= 16'h0;
    pulse(1'b0);
    step(3);
    check("grantValid", {31'h0, grantValid}, 32'h0);
    // The next grant after channel 2 is channel 3, not the highest level 7.
    chanReq <= 16'h0088;
    arb(4'h3, 1'b0);
    test_done();
  end

  // Watchdog well beyond the under two hundred cycles the sequence needs.
  initial begin
    #(25 * 20000);
    bad_count++;
    test_done();
  end
endmodule : tb_top

`default_nettype wire
